// ### include/srx_pkg.sv
// shared constants and types for the receiver control and status block
`default_nettype none
package srx_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL_LO   = 8'h00;
  localparam logic [7:0] OFS_CTRL_HI   = 8'h04;
  localparam logic [7:0] OFS_CONFIG    = 8'h08;
  localparam logic [7:0] OFS_STATUS    = 8'h0c;
  localparam logic [7:0] OFS_INT_STAT  = 8'h10;
  localparam logic [7:0] OFS_INT_CLEAR = 8'h14;
  localparam logic [7:0] OFS_INT_EN    = 8'h18;
  localparam logic [7:0] OFS_PID_CH0   = 8'h1c;
  // reset values
  localparam logic [31:0] RST_CTRL_LO  = 32'h0000_3f21;
  localparam logic [31:0] RST_CTRL_HI  = 32'h0000_0000;
  localparam logic        RST_SW_CTRL  = 1'b0;
  localparam logic [3:0]  RST_INT_EN   = 4'h0;
  // core control word fields
  localparam int CW_MODULE_EN = 0;
  localparam int CW_FRAME_EN  = 4;
  localparam int CW_DETECT_EN = 5;
  localparam int CW_MODE_EN   = 8;
  localparam int CW_FORCED    = 16;
  // interrupt status bits
  localparam int IRQ_LOCK     = 0;
  localparam int IRQ_UNLOCK   = 1;
  localparam int IRQ_T_LOCK   = 2;
  localparam int IRQ_OVERRUN  = 3;
  // stream widths
  localparam int WIDE_BITS    = 40;
  localparam int NARROW_BITS  = 20;
  // timing at 20 MHz
  localparam int CLK_NS          = 50;
  localparam int DWELL_NS        = 50000;
  localparam int DWELL_CYC       = DWELL_NS / CLK_NS;
  localparam int LOSS_NS         = 200000;
  localparam int LOSS_CYC        = LOSS_NS / CLK_NS;
  localparam int TRS_TO_LOCK     = 2;
  // payload id packet words
  localparam logic [7:0] PID_DID  = 8'h41;
  localparam logic [7:0] PID_SDID = 8'h01;
  localparam logic [7:0] PID_DC   = 8'h04;
  typedef enum logic [2:0] {
    MODE_HD = 3'b000, MODE_SD = 3'b001, MODE_3G = 3'b010,
    MODE_6G = 3'b100, MODE_12G = 3'b101, MODE_12GF = 3'b110
  } srx_mode_e;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00, ST_SEARCH = 2'b01, ST_LOCKED = 2'b11
  } srx_state_e;
endpackage
`default_nettype wire

// ### rtl/srx_ctrl_status.sv
// receiver control and status: mode search, transport status, stream, sideband
//
// Operation
// - stream payload is 40 bits for 6G/12G, 20 bits for 3G
// - transport lock rises once the transport format is identified
// - 4-bit transport family, valid only while transport lock is high
// - 4-bit transport frame rate, valid only while transport lock is high
// - transport scan low interlaced, high progressive, valid while locked
// - four 32-bit payload id words, each with its own valid flag
// - raw control, payload id and stream ports only without video option
// - 32-bit sideband words with valid, transferred only while ready
// - one interrupt output for receiver events
// - mode lock low while searching, high once the standard is found
`default_nettype none
module srx_ctrl_status
  import srx_pkg::*;
#(
  parameter bit VIDEO_OUT_OPTION = 1'b0
)(
  input  wire logic        clock,
  input  wire logic        rstn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic [63:0] rawCtrl,
  input  wire logic [9:0]  serialStreamWord1,
  input  wire logic [9:0]  serialStreamWord2,
  input  wire logic [9:0]  serialStreamWord3,
  input  wire logic [9:0]  serialStreamWord4,
  input  wire logic [9:0]  serialStreamWord5,
  input  wire logic [9:0]  serialStreamWord6,
  input  wire logic [9:0]  serialStreamWord7,
  output logic [39:0]      rxStreamPayload,
  output logic [31:0]      rxStreamSideInfo,
  output logic             rxStreamValid,
  input  wire logic        rxStreamReady,
  output logic [31:0]      xcvrCtrlSidebandWord,
  output logic             xcvrCtrlSidebandValid,
  input  wire logic        xcvrCtrlSidebandReady,
  output logic             rxIrq,
  output logic             tLocked,
  output logic [3:0]       tFamily,
  output logic [3:0]       tRate,
  output logic             tScan,
  output logic             modeLocked,
  output logic [2:0]       sdiMode,
  output logic [31:0]      payloadIdWordCh0,
  output logic [31:0]      payloadIdWordCh1,
  output logic [31:0]      payloadIdWordCh2,
  output logic [31:0]      payloadIdWordCh3,
  output logic             payloadIdValidCh0,
  output logic             payloadIdValidCh1,
  output logic             payloadIdValidCh2,
  output logic             payloadIdValidCh3
);
  logic [31:0] ctrlLo;
  logic [31:0] ctrlHi;
  logic        swCtrl;
  logic [3:0]  intStat;
  logic [3:0]  intEn;
  logic [63:0] ctrlWord;
  srx_state_e  state;
  logic [2:0]  mode;
  logic [11:0] timer;
  logic [1:0]  trsCount;
  logic        trsSeen;
  logic        trsEav;
  logic [9:0]  ds [0:6];
  logic [31:0] pidW [0:3];
  logic [3:0]  pidV;
  logic        pidClear;
  logic [2:0]  sbSent;
  logic [3:0]  events;
  logic        overrun;
  logic        apbSetup;
  logic        apbWrite;

  // a mode is usable when its enable bit is set
  function automatic logic modeOk(input logic [2:0] m, input logic [5:0] en);
    case (m)
      MODE_HD:   modeOk = en[0];
      MODE_SD:   modeOk = en[1];
      MODE_3G:   modeOk = en[2];
      MODE_6G:   modeOk = en[3];
      MODE_12G:  modeOk = en[4];
      MODE_12GF: modeOk = en[5];
      default:   modeOk = 1'b0;
    endcase
  endfunction

  function automatic logic [2:0] modeStep(input logic [2:0] m);
    case (m)
      MODE_HD:  modeStep = MODE_SD;
      MODE_SD:  modeStep = MODE_3G;
      MODE_3G:  modeStep = MODE_6G;
      MODE_6G:  modeStep = MODE_12G;
      MODE_12G: modeStep = MODE_12GF;
      default:  modeStep = MODE_HD;
    endcase
  endfunction

  // next enabled mode in search order, stays put when none is enabled
  function automatic logic [2:0] nextMode(input logic [2:0] m, input logic [5:0] en);
    logic [2:0] c;
    c = modeStep(m);
    nextMode = m;
    for (int i = 0; i < 6; i++) begin
      if (modeOk(c, en) && nextMode == m) begin
        nextMode = c;
      end
      c = modeStep(c);
    end
  endfunction

  function automatic logic isWide(input logic [2:0] m);
    isWide = (m == MODE_6G) || (m == MODE_12G) || (m == MODE_12GF);
  endfunction

  // with the video option the raw word is ignored and software owns control
  assign ctrlWord = (swCtrl || VIDEO_OUT_OPTION) ? {ctrlHi, ctrlLo} : rawCtrl;

  assign ds[0] = serialStreamWord1;
  assign ds[1] = serialStreamWord2;
  assign ds[2] = serialStreamWord3;
  assign ds[3] = serialStreamWord4;
  assign ds[4] = serialStreamWord5;
  assign ds[5] = serialStreamWord6;
  assign ds[6] = serialStreamWord7;

  srx_trs_detect uTrs (
    .clock (clock),
    .rstn  (rstn),
    .word  (ds[0]),
    .trs   (trsSeen),
    .eav   (trsEav)
  );

  // luma streams carry the payload id, one channel each
  assign pidClear = (state != ST_LOCKED);
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : gPid
      srx_pid_extract uPid (
        .clock    (clock),
        .rstn     (rstn),
        .clear    (pidClear),
        .word     (ds[2 * g]),
        .pidWord  (pidW[g]),
        .pidValid (pidV[g])
      );
    end
  endgenerate

  // mode search and lock
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state    <= ST_IDLE;
      mode     <= MODE_HD;
      timer    <= 12'd0;
      trsCount <= 2'd0;
    end else if (!ctrlWord[CW_MODULE_EN]) begin
      state    <= ST_IDLE;
      timer    <= 12'd0;
      trsCount <= 2'd0;
    end else begin
      case (state)
        ST_IDLE: begin
          state <= ST_SEARCH;
          // with detection off start in the forced mode, else move off a disabled mode to the next enabled one
          mode  <= !ctrlWord[CW_DETECT_EN] ? ctrlWord[CW_FORCED +: 3]
                 : modeOk(mode, ctrlWord[CW_MODE_EN +: 6]) ? mode
                 : nextMode(mode, ctrlWord[CW_MODE_EN +: 6]);
          timer <= 12'd0;
        end
        ST_SEARCH: begin
          if (trsSeen && trsCount == 2'(TRS_TO_LOCK - 1)) begin
            state    <= ST_LOCKED;
            timer    <= 12'd0;
            trsCount <= 2'd0;
          end else if (timer == 12'(DWELL_CYC - 1)) begin
            timer    <= 12'd0;
            trsCount <= 2'd0;
            mode     <= ctrlWord[CW_DETECT_EN]
                      ? nextMode(mode, ctrlWord[CW_MODE_EN +: 6])
                      : ctrlWord[CW_FORCED +: 3];
          end else begin
            timer    <= timer + 12'd1;
            trsCount <= trsCount + {1'b0, trsSeen};
          end
        end
        ST_LOCKED: begin
          if (trsSeen) begin
            timer <= 12'd0;
          end else if (timer == 12'(LOSS_CYC - 1)) begin
            state <= ST_SEARCH;
            timer <= 12'd0;
          end else begin
            timer <= timer + 12'd1;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      modeLocked <= 1'b0;
      sdiMode    <= MODE_HD;
    end else begin
      modeLocked <= (state == ST_LOCKED);
      sdiMode    <= mode;
    end
  end

  // transport status is forced to zero whenever it is not valid
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      tLocked <= 1'b0;
      tFamily <= 4'h0;
      tRate   <= 4'h0;
      tScan   <= 1'b0;
    end else if (state == ST_LOCKED && pidV[0]) begin
      tLocked <= 1'b1;
      tFamily <= pidW[0][3:0];
      tRate   <= pidW[0][11:8];
      tScan   <= pidW[0][14];
    end else begin
      tLocked <= 1'b0;
      tFamily <= 4'h0;
      tRate   <= 4'h0;
      tScan   <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      payloadIdWordCh0  <= 32'h0;
      payloadIdWordCh1  <= 32'h0;
      payloadIdWordCh2  <= 32'h0;
      payloadIdWordCh3  <= 32'h0;
      payloadIdValidCh0 <= 1'b0;
      payloadIdValidCh1 <= 1'b0;
      payloadIdValidCh2 <= 1'b0;
      payloadIdValidCh3 <= 1'b0;
    end else if (!VIDEO_OUT_OPTION) begin
      payloadIdWordCh0  <= pidW[0];
      payloadIdWordCh1  <= pidW[1];
      payloadIdWordCh2  <= pidW[2];
      payloadIdWordCh3  <= pidW[3];
      payloadIdValidCh0 <= pidV[0];
      payloadIdValidCh1 <= pidV[1];
      payloadIdValidCh2 <= pidV[2];
      payloadIdValidCh3 <= pidV[3];
    end
  end

  // receive stream: a sample that meets a stalled slot is dropped and flagged
  assign overrun = rxStreamValid && !rxStreamReady && state == ST_LOCKED;
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rxStreamValid    <= 1'b0;
      rxStreamPayload  <= 40'h0;
      rxStreamSideInfo <= 32'h0;
    end else if (!rxStreamValid || rxStreamReady) begin
      rxStreamValid <= (state == ST_LOCKED) && ctrlWord[CW_FRAME_EN] && !VIDEO_OUT_OPTION;
      rxStreamPayload <= isWide(mode)
                       ? {ds[3], ds[2], ds[1], ds[0]}
                       : {20'h0, ds[1], ds[0]};
      rxStreamSideInfo <= {24'h0, trsEav, trsSeen, isWide(mode), 2'b00, mode};
    end
  end

  // one sideband word per mode change, held until the transceiver takes it
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      xcvrCtrlSidebandValid <= 1'b0;
      xcvrCtrlSidebandWord  <= 32'h0;
      sbSent                <= 3'b111;
    end else if (!xcvrCtrlSidebandValid || xcvrCtrlSidebandReady) begin
      if (sbSent != mode) begin
        xcvrCtrlSidebandValid <= 1'b1;
        xcvrCtrlSidebandWord  <= {29'h0, mode};
        sbSent                <= mode;
      end else begin
        xcvrCtrlSidebandValid <= 1'b0;
      end
    end
  end

  // sticky event bits, set beats a same-cycle clear
  assign events[IRQ_LOCK]    = (state == ST_LOCKED) && !modeLocked;
  assign events[IRQ_UNLOCK]  = (state != ST_LOCKED) && modeLocked;
  assign events[IRQ_T_LOCK]  = (state == ST_LOCKED) && pidV[0] && !tLocked;
  assign events[IRQ_OVERRUN] = overrun;

  assign apbSetup = psel && !penable && !pready;
  assign apbWrite = psel && penable && pready && pwrite;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      intStat <= 4'h0;
    end else begin
      intStat <= (intStat & ~((apbWrite && paddr == OFS_INT_CLEAR) ? pwdata[3:0] : 4'h0))
               | events;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rxIrq <= 1'b0;
    end else begin
      rxIrq <= |(intStat & intEn);
    end
  end

  // apb slave: fixed zero-wait answer, writes land at the access edge
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ctrlLo <= RST_CTRL_LO;
      ctrlHi <= RST_CTRL_HI;
      swCtrl <= RST_SW_CTRL;
      intEn  <= RST_INT_EN;
    end else if (apbWrite) begin
      case (paddr)
        OFS_CTRL_LO: ctrlLo <= pwdata;
        OFS_CTRL_HI: ctrlHi <= pwdata;
        OFS_CONFIG:  swCtrl <= pwdata[0];
        OFS_INT_EN:  intEn  <= pwdata[3:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end else if (apbSetup) begin
      pready  <= 1'b1;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
      case (paddr)
        OFS_CTRL_LO:   prdata <= ctrlLo;
        OFS_CTRL_HI:   prdata <= ctrlHi;
        OFS_CONFIG:    prdata <= {31'h0, swCtrl};
        OFS_STATUS:    prdata <= {15'h0, tScan, tRate, tFamily, 3'h0, tLocked, sdiMode, modeLocked};
        OFS_INT_STAT:  prdata <= {28'h0, intStat};
        OFS_INT_CLEAR: prdata <= 32'h0;
        OFS_INT_EN:    prdata <= {28'h0, intEn};
        OFS_PID_CH0:   prdata <= payloadIdWordCh0;
        default:       pslverr <= 1'b1;
      endcase
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end
endmodule // srx_ctrl_status
`default_nettype wire

// ### rtl/srx_pid_extract.sv
// payload identifier packet capture on one 10-bit stream
`default_nettype none
module srx_pid_extract
  import srx_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rstn,
  input  wire logic        clear,
  input  wire logic [9:0]  word,
  output logic [31:0]      pidWord,
  output logic             pidValid
);
  logic [3:0]  step;
  logic [31:0] shift;
  logic [3:0]  next_step;

  // step 0..2 ancillary flag, 3 did, 4 sdid, 5 dc, 6..9 user words
  always_comb begin
    next_step = 4'd0;
    case (step)
      4'd0: next_step = (word == 10'h000) ? 4'd1 : 4'd0;
      4'd1: next_step = (word == 10'h3ff) ? 4'd2 : 4'd0;
      4'd2: next_step = (word == 10'h3ff) ? 4'd3 : 4'd0;
      4'd3: next_step = (word[7:0] == PID_DID) ? 4'd4 : 4'd0;
      4'd4: next_step = (word[7:0] == PID_SDID) ? 4'd5 : 4'd0;
      4'd5: next_step = (word[7:0] == PID_DC) ? 4'd6 : 4'd0;
      4'd6, 4'd7, 4'd8: next_step = step + 4'd1;
      default: next_step = 4'd0;
    endcase
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      step  <= 4'd0;
      shift <= 32'h0;
    end else begin
      step <= next_step;
      if (step >= 4'd6) begin
        shift <= {word[7:0], shift[31:8]};
      end
    end
  end

  // valid stays up until the channel loses lock
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pidWord  <= 32'h0;
      pidValid <= 1'b0;
    end else if (clear) begin
      pidValid <= 1'b0;
    end else if (step == 4'd9) begin
      // last user word is still on the input, not yet in the shifter
      pidWord  <= {word[7:0], shift[31:8]};
      pidValid <= 1'b1;
    end
  end
endmodule // srx_pid_extract
`default_nettype wire

// ### rtl/srx_trs_detect.sv
// timing reference sequence detector on one 10-bit stream
`default_nettype none
module srx_trs_detect
  import srx_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       rstn,
  input  wire logic [9:0] word,
  output logic            trs,
  output logic            eav
);
  logic [1:0] run;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      run <= 2'd0;
    end else if (word == 10'h3ff) begin
      run <= 2'd1;
    end else if (word == 10'h000 && run != 2'd0 && run != 2'd3) begin
      run <= run + 2'd1;
    end else begin
      run <= 2'd0;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      trs <= 1'b0;
      eav <= 1'b0;
    end else begin
      trs <= (run == 2'd3);
      eav <= (run == 2'd3) && word[6];
    end
  end
endmodule // srx_trs_detect
`default_nettype wire

// ### tb/srx_ctrl_status_properties.sv
// concurrent checks on the receiver control and status ports
`default_nettype none
module srx_ctrl_status_properties
  import srx_pkg::*;
(
  input wire logic        clock,
  input wire logic        rstn,
  input wire logic [39:0] rxStreamPayload,
  input wire logic [31:0] rxStreamSideInfo,
  input wire logic        rxStreamValid,
  input wire logic        rxStreamReady,
  input wire logic [31:0] xcvrCtrlSidebandWord,
  input wire logic        xcvrCtrlSidebandValid,
  input wire logic        xcvrCtrlSidebandReady,
  input wire logic        tLocked,
  input wire logic [3:0]  tFamily,
  input wire logic [3:0]  tRate,
  input wire logic        tScan,
  input wire logic        modeLocked,
  input wire logic [2:0]  sdiMode,
  input wire logic [31:0] payloadIdWordCh0,
  input wire logic        payloadIdValidCh0
);
  timeunit 1ns;
  timeprecision 1ns;
  logic wideMode;
  assign wideMode = rxStreamSideInfo[2:0] inside {MODE_6G, MODE_12G, MODE_12GF};
  default clocking dc @(posedge clock);
  endclocking
  default disable iff (!rstn);
  sequence sbStall;
    xcvrCtrlSidebandValid && !xcvrCtrlSidebandReady;
  endsequence
  sequence streamStall;
    rxStreamValid && !rxStreamReady;
  endsequence
  a_width_narrow: assert property (
    rxStreamValid && !wideMode |-> rxStreamPayload[39:20] == 20'h0)
    else $error("narrow payload upper half not zero");
  a_wide_flag: assert property (
    rxStreamValid |-> rxStreamSideInfo[5] == wideMode)
    else $error("wide flag disagrees with mode");
  a_stream_hold: assert property (
    streamStall |=> rxStreamValid && $stable(rxStreamPayload))
    else $error("stalled stream sample changed");
  a_tport_gate: assert property (
    !tLocked |-> tFamily == 4'h0 && tRate == 4'h0 && !tScan)
    else $error("transport fields set while unlocked");
  a_tport_fields: assert property (
    tLocked |-> tFamily == payloadIdWordCh0[3:0] && tRate == payloadIdWordCh0[11:8]
      && tScan == payloadIdWordCh0[14])
    else $error("transport fields differ from payload id");
  a_sb_hold: assert property (
    sbStall |=> xcvrCtrlSidebandValid && $stable(xcvrCtrlSidebandWord))
    else $error("sideband word dropped or changed while stalled");
  a_sb_word: assert property (
    xcvrCtrlSidebandValid |-> xcvrCtrlSidebandWord[31:3] == 29'h0)
    else $error("sideband word upper bits set");
  a_sb_follow: assert property (
    $changed(sdiMode) && !$past(xcvrCtrlSidebandValid)
    |-> ##[0:1] (xcvrCtrlSidebandValid && xcvrCtrlSidebandWord[2:0] == sdiMode))
    else $error("mode change not sent on sideband");
  a_mode_steady: assert property (
    modeLocked && $past(modeLocked) |-> $stable(sdiMode))
    else $error("mode changed while locked");
  a_pid_drop: assert property (
    !modeLocked [*3] |-> !payloadIdValidCh0)
    else $error("payload id valid while unlocked");
endmodule // srx_ctrl_status_properties
`default_nettype wire

// ### tb/srx_ctrl_status_tb.sv
// self-checking bench for the receiver control and status block
`default_nettype none
module srx_ctrl_status_tb
  import srx_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clock = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        trsOn = 1'b1, stallStream = 1'b0, stallSb = 1'b0, err, wide;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, rd;
  logic [63:0] rawCtrl = 64'h3f31;
  logic        pready, pslverr, rxStreamValid, rxStreamReady, xcvrCtrlSidebandValid, rxIrq;
  logic        xcvrCtrlSidebandReady, tLocked, tScan, modeLocked;
  logic        payloadIdValidCh0, payloadIdValidCh1, payloadIdValidCh2, payloadIdValidCh3;
  logic [31:0] prdata, rxStreamSideInfo, xcvrCtrlSidebandWord;
  logic [31:0] payloadIdWordCh0, payloadIdWordCh1, payloadIdWordCh2, payloadIdWordCh3;
  logic [39:0] rxStreamPayload;
  logic [9:0]  ds1, ds2, ds3, ds4, ds5, ds6, ds7;
  logic [3:0]  tFamily, tRate;
  logic [2:0]  sdiMode;
  int          nMismatch = 0, nChecks = 0;
  logic [63:0] ctrlTab [7] = '{64'h3f31, 64'h0231, 64'h0431, 64'h1031, 64'h2031,
                               64'h4_0011, 64'h1_0011};
  logic [2:0]  modeTab [7] = '{MODE_HD, MODE_SD, MODE_3G, MODE_12G, MODE_12GF, MODE_6G, MODE_SD};

  srx_ctrl_status DUT (.clock(clock), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .rawCtrl(rawCtrl), .serialStreamWord1(ds1), .serialStreamWord2(ds2),
    .serialStreamWord3(ds3), .serialStreamWord4(ds4), .serialStreamWord5(ds5),
    .serialStreamWord6(ds6), .serialStreamWord7(ds7), .rxStreamPayload(rxStreamPayload),
    .rxStreamSideInfo(rxStreamSideInfo), .rxStreamValid(rxStreamValid),
    .rxStreamReady(rxStreamReady), .xcvrCtrlSidebandWord(xcvrCtrlSidebandWord),
    .xcvrCtrlSidebandValid(xcvrCtrlSidebandValid), .xcvrCtrlSidebandReady(xcvrCtrlSidebandReady),
    .rxIrq(rxIrq), .tLocked(tLocked), .tFamily(tFamily), .tRate(tRate), .tScan(tScan),
    .modeLocked(modeLocked), .sdiMode(sdiMode), .payloadIdWordCh0(payloadIdWordCh0),
    .payloadIdWordCh1(payloadIdWordCh1), .payloadIdWordCh2(payloadIdWordCh2),
    .payloadIdWordCh3(payloadIdWordCh3), .payloadIdValidCh0(payloadIdValidCh0),
    .payloadIdValidCh1(payloadIdValidCh1), .payloadIdValidCh2(payloadIdValidCh2),
    .payloadIdValidCh3(payloadIdValidCh3));

  srx_far_side u_far (.clock(clock), .rstn(rstn), .trsOn(trsOn), .stallStream(stallStream),
    .stallSb(stallSb), .serialStreamWord1(ds1), .serialStreamWord2(ds2),
    .serialStreamWord3(ds3), .serialStreamWord4(ds4), .serialStreamWord5(ds5),
    .serialStreamWord6(ds6), .serialStreamWord7(ds7), .rxStreamReady(rxStreamReady),
    .xcvrCtrlSidebandReady(xcvrCtrlSidebandReady));

  always #25 clock = ~clock;

  task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
    nChecks++;
    if (seen !== exp) begin
      nMismatch++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic results();
    if (nMismatch == 0 && nChecks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // one apb transfer; holds the request until pready is seen at an edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n = 0;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 50);
    check("pready", pready, 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic waitLock(input logic lvl);
    int n = 0;
    while (modeLocked !== lvl && n < 8000) begin
      @(posedge clock);
      n++;
    end
    check("lock wait", n < 8000, 1'b1);
  endtask

  initial begin
    repeat (8) @(posedge clock);
    rstn <= 1'b1;
    waitLock(1'b1);
    for (int n = 0; n < 500 && tLocked !== 1'b1; n++) @(posedge clock);
    check("tlock", tLocked, 1'b1);
    check("family", tFamily, 4'h5);
    check("rate", tRate, 4'ha);
    check("scan", tScan, 1'b1);
    check("pid ch0", {payloadIdValidCh0, payloadIdWordCh0}, {1'b1, 32'h8012_4a35});
    check("pid ch1-3", {payloadIdValidCh1, payloadIdValidCh2, payloadIdValidCh3}, 3'h0);
    apb(1'b0, OFS_PID_CH0, 32'h0);
    check("pid reg", rd, 32'h8012_4a35);
    apb(1'b0, OFS_STATUS, 32'h0);
    check("status", rd, 32'h0001_a511);
    apb(1'b0, OFS_INT_STAT, 32'h0);
    check("int stat", rd, 32'h5);
    check("irq masked", rxIrq, 1'b0);
    apb(1'b1, OFS_INT_EN, 32'h5);
    repeat (2) @(posedge clock);
    check("irq raised", rxIrq, 1'b1);
    apb(1'b1, OFS_INT_CLEAR, 32'h5);
    repeat (2) @(posedge clock);
    check("irq cleared", rxIrq, 1'b0);
    apb(1'b0, 8'h40, 32'h0);
    check("unmapped", {err, rd}, {1'b1, 32'h0});
    // stall the stream long enough to lose samples
    stallStream <= 1'b1;
    repeat (6) @(posedge clock);
    stallStream <= 1'b0;
    apb(1'b0, OFS_INT_STAT, 32'h0);
    check("overrun", rd[3], 1'b1);
    apb(1'b1, OFS_INT_CLEAR, 32'hf);
    for (int i = 0; i < 7; i++) begin
      rawCtrl <= 64'h0;
      if (i == 1) stallSb <= 1'b1;
      repeat (4) @(posedge clock);
      rawCtrl <= ctrlTab[i];
      waitLock(1'b1);
      repeat (2) @(posedge clock);
      wide = modeTab[i] inside {MODE_6G, MODE_12G, MODE_12GF};
      check("mode", sdiMode, modeTab[i]);
      check("side mode", {rxStreamSideInfo[5], rxStreamSideInfo[2:0]}, {wide, modeTab[i]});
      check("payload", {rxStreamValid, rxStreamPayload[39:10]},
            {1'b1, wide ? {10'h0c4, 10'h0b3} : 20'h0, 10'h1a2});
      if (i == 1) begin
        check("sideband", {xcvrCtrlSidebandValid, xcvrCtrlSidebandWord}, {1'b1, 32'h1});
        stallSb <= 1'b0;
      end
    end
    // without timing references the lock must drop
    apb(1'b1, OFS_INT_CLEAR, 32'hf);
    trsOn <= 1'b0;
    waitLock(1'b0);
    repeat (4) @(posedge clock);
    check("unlocked", {tLocked, tFamily, tRate, tScan, payloadIdValidCh0}, 11'h0);
    apb(1'b0, OFS_INT_STAT, 32'h0);
    check("unlock event", rd[1], 1'b1);
    results();
  end

  initial begin
    repeat (20000) @(posedge clock);
    nMismatch++;
    results();
  end
endmodule // srx_ctrl_status_tb

bind srx_ctrl_status srx_ctrl_status_properties u_props (.clock(clock), .rstn(rstn),
  .rxStreamPayload(rxStreamPayload), .rxStreamSideInfo(rxStreamSideInfo),
  .rxStreamValid(rxStreamValid), .rxStreamReady(rxStreamReady),
  .xcvrCtrlSidebandWord(xcvrCtrlSidebandWord), .xcvrCtrlSidebandValid(xcvrCtrlSidebandValid),
  .xcvrCtrlSidebandReady(xcvrCtrlSidebandReady), .tLocked(tLocked), .tFamily(tFamily),
  .tRate(tRate), .tScan(tScan), .modeLocked(modeLocked), .sdiMode(sdiMode),
  .payloadIdWordCh0(payloadIdWordCh0), .payloadIdValidCh0(payloadIdValidCh0));
`default_nettype wire

// ### tb/srx_far_side.sv
// far-side model: transceiver data streams and ready for stream and sideband
`default_nettype none
module srx_far_side
  import srx_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       rstn,
  input  wire logic       trsOn,
  input  wire logic       stallStream,
  input  wire logic       stallSb,
  output logic [9:0]      serialStreamWord1,
  output logic [9:0]      serialStreamWord2,
  output logic [9:0]      serialStreamWord3,
  output logic [9:0]      serialStreamWord4,
  output logic [9:0]      serialStreamWord5,
  output logic [9:0]      serialStreamWord6,
  output logic [9:0]      serialStreamWord7,
  output logic            rxStreamReady,
  output logic            xcvrCtrlSidebandReady
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [5:0] phase;
  // distinct constants so a swapped lane shows in the payload
  assign serialStreamWord2 = 10'h1a2;
  assign serialStreamWord3 = 10'h0b3;
  assign serialStreamWord4 = 10'h0c4;
  assign serialStreamWord5 = 10'h0d5;
  assign serialStreamWord6 = 10'h0e6;
  assign serialStreamWord7 = 10'h0f7;
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      phase <= 6'h00;
      serialStreamWord1 <= 10'h040;
      rxStreamReady <= 1'b0;
      xcvrCtrlSidebandReady <= 1'b0;
    end else begin
      phase <= phase + 6'h01;
      rxStreamReady <= !stallStream;
      xcvrCtrlSidebandReady <= !stallSb;
      case (phase)
        6'h00: serialStreamWord1 <= trsOn ? 10'h3ff : 10'h040;
        6'h01, 6'h02, 6'h08: serialStreamWord1 <= trsOn ? 10'h000 : 10'h040;
        6'h03: serialStreamWord1 <= trsOn ? 10'h2d8 : 10'h040;
        6'h09, 6'h0a: serialStreamWord1 <= 10'h3ff;
        6'h0b: serialStreamWord1 <= {2'h0, PID_DID};
        6'h0c: serialStreamWord1 <= {2'h0, PID_SDID};
        6'h0d: serialStreamWord1 <= {2'h0, PID_DC};
        6'h0e: serialStreamWord1 <= 10'h235;
        6'h0f: serialStreamWord1 <= 10'h24a;
        6'h10: serialStreamWord1 <= 10'h212;
        6'h11: serialStreamWord1 <= 10'h280;
        default: serialStreamWord1 <= 10'h040;
      endcase
    end
  end
endmodule // srx_far_side
`default_nettype wire
